// *** src/isadec_pkg.sv ***
// shared constants and types of the instruction decoder
package isadec_pkg;
    // field positions
    localparam int OPC_MSB = 31;
    localparam int OPC_LSB = 26;
    localparam int FP_FN_MSB = 15;
    localparam int FP_FN_LSB = 5;
    localparam int OP_FN_MSB = 11;
    localparam int OP_FN_LSB = 5;
    localparam int HINT_MSB = 15;
    localparam int HINT_LSB = 14;
    localparam int MEM_FN_MSB = 15;
    localparam int MEM_FN_LSB = 0;
    localparam int PRIV_FN_MSB = 25;
    localparam int PRIV_FN_LSB = 0;

    // major opcodes
    localparam logic [5:0] OPC_PRIV_CALL = 6'h00;
    localparam logic [5:0] OPC_RSV_LO    = 6'h01;
    localparam logic [5:0] OPC_RSV_HI    = 6'h07;
    localparam logic [5:0] OPC_BYTE_LD   = 6'h0A;
    localparam logic [5:0] OPC_WORD_LD   = 6'h0C;
    localparam logic [5:0] OPC_WORD_ST   = 6'h0D;
    localparam logic [5:0] OPC_BYTE_ST   = 6'h0E;
    localparam logic [5:0] OPC_INT_ARITH = 6'h10;
    localparam logic [5:0] OPC_INT_LOGIC = 6'h11;
    localparam logic [5:0] OPC_INT_SHIFT = 6'h12;
    localparam logic [5:0] OPC_INT_MUL   = 6'h13;
    localparam logic [5:0] OPC_FP_LEGACY = 6'h15;
    localparam logic [5:0] OPC_FP_IEEE   = 6'h16;
    localparam logic [5:0] OPC_FP_MISC   = 6'h17;
    localparam logic [5:0] OPC_MISC      = 6'h18;
    localparam logic [5:0] OPC_IREG_RD   = 6'h19;
    localparam logic [5:0] OPC_JUMP      = 6'h1A;
    localparam logic [5:0] OPC_HW_LOAD   = 6'h1B;
    localparam logic [5:0] OPC_IREG_WR   = 6'h1D;
    localparam logic [5:0] OPC_EXC_RET   = 6'h1E;
    localparam logic [5:0] OPC_HW_STORE  = 6'h1F;
    localparam logic [5:0] OPC_BR_LBC    = 6'h38;
    localparam logic [5:0] OPC_BR_LBS    = 6'h3C;

    // integer function codes
    localparam logic [6:0] FN_INT_CMP_EQ  = 7'h2D;
    localparam logic [6:0] FN_INT_CMP_LT  = 7'h4D;
    localparam logic [6:0] FN_INT_CMP_LE  = 7'h6D;
    localparam logic [6:0] FN_LOGIC_AND   = 7'h00;
    localparam logic [6:0] FN_LOGIC_ORNC  = 7'h28;
    localparam logic [6:0] FN_LOGIC_XOR   = 7'h40;
    localparam logic [6:0] FN_MUL_LONG    = 7'h00;
    localparam logic [6:0] FN_MUL_UHIGH   = 7'h30;
    // floating function codes
    localparam logic [10:0] FN_IEEE_CMP_LE  = 11'h0A7;
    localparam logic [10:0] FN_IEEE_CMP_UN  = 11'h0A4;
    localparam logic [10:0] FN_LEG_CMP_EQ   = 11'h0A5;
    localparam logic [10:0] FN_LEG_CMP_LE   = 11'h0A7;
    localparam logic [10:0] FN_CVT_S_TO_D   = 11'h2AC;
    localparam logic [10:0] FN_FPCR_READ    = 11'h025;
    localparam logic [10:0] FN_FPCR_WRITE   = 11'h024;
    // memory function code
    localparam logic [15:0] FN_CYCLE_READ   = 16'h00C0;
    // jump hints
    localparam logic [1:0] HINT_JMP  = 2'h0;
    localparam logic [1:0] HINT_JSR  = 2'h1;
    localparam logic [1:0] HINT_RET  = 2'h2;
    localparam logic [1:0] HINT_CORO = 2'h3;

    // instruction formats, one-hot
    typedef enum logic [6:0] {
        FMT_BRANCH = 7'h01,
        FMT_FLOAT  = 7'h02,
        FMT_MEMORY = 7'h04,
        FMT_MEMFN  = 7'h08,
        FMT_MEMBR  = 7'h10,
        FMT_OPER   = 7'h20,
        FMT_PRIV   = 7'h40
    } isadec_fmt_e;

    // decoded hardware operations
    typedef enum logic [4:0] {
        OP_NOP, OP_OTHER,
        OP_INT_CMP_EQUAL, OP_INT_CMP_LESS, OP_INT_CMP_LESS_EQUAL,
        OP_LOGIC_AND, OP_LOGIC_OR_COMPLEMENT, OP_LOGIC_XOR,
        OP_MUL_LONGWORD, OP_MUL_UNSIGNED_HIGH,
        OP_IEEE_DBL_CMP_LESS_EQUAL, OP_IEEE_DBL_CMP_UNORDERED,
        OP_LEGACY_DBL_CMP_EQUAL, OP_LEGACY_DBL_CMP_LESS_EQUAL,
        OP_CVT_SINGLE_TO_DOUBLE, OP_FP_CTRL_READ, OP_FP_CTRL_WRITE,
        OP_CYCLE_COUNTER_READ, OP_BRANCH_LOW_BIT_CLEAR, OP_BRANCH_LOW_BIT_SET,
        OP_JUMP, OP_JUMP_SUBROUTINE, OP_JUMP_RETURN, OP_COROUTINE_JUMP,
        OP_PRIV_HW_LOAD, OP_PRIV_HW_STORE, OP_PRIV_RETURN_FROM_EXCEPTION,
        OP_PRIV_INTERNAL_REG_READ, OP_PRIV_INTERNAL_REG_WRITE, OP_PRIV_CALL
    } isadec_op_e;
endpackage

// *** src/isadec_fields_if.sv ***
// field bundle from the extractor to the decoder
`timescale 1ns/100ps
interface isadec_fields_if;
    import isadec_pkg::*;
    logic [5:0]  opcode;   // major opcode
    logic [6:0]  opFn;     // integer function code
    logic [10:0] fpFn;     // floating function code
    logic [15:0] memFn;    // displacement function code
    logic [1:0]  jumpHint; // jump hint
    logic [25:0] privFn;   // privileged-call function
    modport src (output opcode, opFn, fpFn, memFn, jumpHint, privFn);
    modport dst (input opcode, opFn, fpFn, memFn, jumpHint, privFn);
endinterface

// *** src/isadec_field_extract.sv ***
// splits an instruction word into its fields
`timescale 1ns/100ps
module isadec_field_extract
    import isadec_pkg::*;
(
    input  wire logic [31:0] instrWord, // fetched word
    isadec_fields_if.src     fields     // extracted fields
);
    // every format shares the major opcode slot
    assign fields.opcode   = instrWord[OPC_MSB:OPC_LSB];   // RL1
    assign fields.opFn     = instrWord[OP_FN_MSB:OP_FN_LSB]; // RL5
    assign fields.fpFn     = instrWord[FP_FN_MSB:FP_FN_LSB]; // RL2
    assign fields.memFn    = instrWord[MEM_FN_MSB:MEM_FN_LSB]; // RL3
    assign fields.jumpHint = instrWord[HINT_MSB:HINT_LSB]; // RL4
    assign fields.privFn   = instrWord[PRIV_FN_MSB:PRIV_FN_LSB]; // RL6
endmodule

// *** src/isadec_opcode_decoder.sv ***
// registered opcode decoder
`timescale 1ns/100ps
// How it works
// [RL1] six-bit major opcode selects every format
// [RL2] floating format uses eleven-bit function code
// [RL3] memory-function takes sixteen-bit displacement code
// [RL4] jump kind from two high displacement bits
// [RL5] integer operate uses seven-bit function code
// [RL6] privileged call uses twenty-six-bit function
// [RL7] opcode 10 compares: 2D, 4D, 6D
// [RL8] opcode 11: and 00, or-complement 28, xor 40
// [RL9] opcode 13: longword 00, unsigned high 30
// [RL10] opcode 16: compare le A7, unordered A4
// [RL11] opcode 15: compare eq A5, le A7
// [RL12] opcode 16 code 2AC converts single-double
// [RL13] opcode 17: control read 025, write 024
// [RL14] opcode 18 code C0 reads cycle counter
// [RL15] opcodes 38/3C branch on low bit
// [RL16] opcode 1A hint 3 is coroutine jump
// [RL17] opcodes 01 to 07 are reserved
// [RL18] 0A,0C-0E reserved when byte/word disabled
// [RL19] opcode 1B is privileged hardware load
// [RL20] opcode 1F is privileged hardware store
// [RL21] opcode 1E returns to exception pc
// [RL22] opcodes 19/1D read/write internal registers
// [RL23] undefined opcode 13 and 18 function codes flagged illegal
// [RL24] outputs registered, nop during reset
module isadec_opcode_decoder
    import isadec_pkg::*;
(
    input  wire logic        core_clk,        // core clock
    input  wire logic        sys_rst,         // synchronous reset, high
    input  wire logic        instrValid,      // word present this cycle
    input  wire logic [31:0] instrWord,       // fetched word
    input  wire logic        byteWordEnable,  // byte/word memory ops on
    output isadec_op_e       decodedOp,       // decoded operation
    output isadec_fmt_e      decodedFmt,      // instruction format
    output logic             decodeValid,     // outputs hold a decode
    output logic             illegalInstr,    // reserved or undefined
    output logic [5:0]       opcodeOut,       // major opcode
    output logic [25:0]      functionCode,    // format function field
    output logic             redirectToExcPc  // flow goes to exception pc
);
    isadec_fields_if fieldBus();

    isadec_op_e  next_decodedOp;
    isadec_fmt_e next_decodedFmt;
    logic        next_illegal;
    logic [25:0] next_fnCode;

    // field extraction
    isadec_field_extract uExtract (
        .instrWord (instrWord),
        .fields    (fieldBus.src)
    );

    // format from major opcode
    function automatic isadec_fmt_e fmtOf(input logic [5:0] opc);
        isadec_fmt_e f;
        f = FMT_MEMORY;
        if (opc == OPC_PRIV_CALL) begin
            f = FMT_PRIV;
        end else if (opc >= 6'h30) begin
            f = FMT_BRANCH;
        end else if (opc == OPC_FP_LEGACY || opc == OPC_FP_IEEE || opc == OPC_FP_MISC) begin
            f = FMT_FLOAT; // RL2
        end else if ((opc >= OPC_INT_ARITH && opc <= OPC_INT_MUL) || opc == 6'h1C) begin
            f = FMT_OPER; // RL5
        end else if (opc == OPC_MISC) begin
            f = FMT_MEMFN; // RL3
        end else if (opc == OPC_JUMP) begin
            f = FMT_MEMBR; // RL4
        end
        return f;
    endfunction

    // reserved-opcode check
    function automatic logic isReserved(input logic [5:0] opc, input logic bwEn);
        logic r;
        r = (opc >= OPC_RSV_LO && opc <= OPC_RSV_HI); // RL17
        if (!bwEn && (opc == OPC_BYTE_LD || opc == OPC_WORD_LD ||
                      opc == OPC_WORD_ST || opc == OPC_BYTE_ST)) begin
            r = 1'b1; // RL18
        end
        return r;
    endfunction

    // combinational decode of the current word
    always_comb begin
        next_decodedOp  = OP_OTHER;
        next_decodedFmt = fmtOf(fieldBus.opcode); // RL1
        next_illegal    = 1'b0;
        next_fnCode     = 26'h0;
        case (next_decodedFmt)
            FMT_FLOAT: next_fnCode = {15'h0, fieldBus.fpFn};
            FMT_MEMFN: next_fnCode = {10'h0, fieldBus.memFn};
            FMT_MEMBR: next_fnCode = {24'h0, fieldBus.jumpHint};
            FMT_OPER:  next_fnCode = {19'h0, fieldBus.opFn};
            FMT_PRIV:  next_fnCode = fieldBus.privFn; // RL6
            default:   next_fnCode = 26'h0;
        endcase
        case (fieldBus.opcode)
            OPC_PRIV_CALL: next_decodedOp = OP_PRIV_CALL; // RL6
            OPC_INT_ARITH: begin
                case (fieldBus.opFn)
                    FN_INT_CMP_EQ: next_decodedOp = OP_INT_CMP_EQUAL;      // RL7
                    FN_INT_CMP_LT: next_decodedOp = OP_INT_CMP_LESS;       // RL7
                    FN_INT_CMP_LE: next_decodedOp = OP_INT_CMP_LESS_EQUAL; // RL7
                    default:       next_decodedOp = OP_OTHER;
                endcase
            end
            OPC_INT_LOGIC: begin
                case (fieldBus.opFn)
                    FN_LOGIC_AND:  next_decodedOp = OP_LOGIC_AND;           // RL8
                    FN_LOGIC_ORNC: next_decodedOp = OP_LOGIC_OR_COMPLEMENT; // RL8
                    FN_LOGIC_XOR:  next_decodedOp = OP_LOGIC_XOR;           // RL8
                    default:       next_decodedOp = OP_OTHER;
                endcase
            end
            OPC_INT_MUL: begin
                case (fieldBus.opFn)
                    FN_MUL_LONG:  next_decodedOp = OP_MUL_LONGWORD;      // RL9
                    FN_MUL_UHIGH: next_decodedOp = OP_MUL_UNSIGNED_HIGH; // RL9
                    7'h20, 7'h40, 7'h60: next_decodedOp = OP_OTHER;
                    default: next_illegal = 1'b1; // RL23
                endcase
            end
            OPC_FP_IEEE: begin
                case (fieldBus.fpFn)
                    FN_IEEE_CMP_LE: next_decodedOp = OP_IEEE_DBL_CMP_LESS_EQUAL; // RL10
                    FN_IEEE_CMP_UN: next_decodedOp = OP_IEEE_DBL_CMP_UNORDERED;  // RL10
                    FN_CVT_S_TO_D:  next_decodedOp = OP_CVT_SINGLE_TO_DOUBLE;    // RL12
                    default:        next_decodedOp = OP_OTHER;
                endcase
            end
            OPC_FP_LEGACY: begin
                case (fieldBus.fpFn)
                    FN_LEG_CMP_EQ: next_decodedOp = OP_LEGACY_DBL_CMP_EQUAL;      // RL11
                    FN_LEG_CMP_LE: next_decodedOp = OP_LEGACY_DBL_CMP_LESS_EQUAL; // RL11
                    default:       next_decodedOp = OP_OTHER;
                endcase
            end
            OPC_FP_MISC: begin
                case (fieldBus.fpFn)
                    FN_FPCR_READ:  next_decodedOp = OP_FP_CTRL_READ;  // RL13
                    FN_FPCR_WRITE: next_decodedOp = OP_FP_CTRL_WRITE; // RL13
                    default:       next_decodedOp = OP_OTHER;
                endcase
            end
            OPC_MISC: begin
                case (fieldBus.memFn)
                    FN_CYCLE_READ: next_decodedOp = OP_CYCLE_COUNTER_READ; // RL14
                    16'h0000, 16'h0400, 16'h4000, 16'h4400, 16'h8000,
                    16'hA000, 16'hE000, 16'hF000: next_decodedOp = OP_OTHER;
                    default: next_illegal = 1'b1; // RL23
                endcase
            end
            OPC_JUMP: begin
                case (fieldBus.jumpHint)
                    HINT_JMP:  next_decodedOp = OP_JUMP;            // RL4
                    HINT_JSR:  next_decodedOp = OP_JUMP_SUBROUTINE; // RL4
                    HINT_RET:  next_decodedOp = OP_JUMP_RETURN;     // RL4
                    HINT_CORO: next_decodedOp = OP_COROUTINE_JUMP;  // RL16
                    default:   next_decodedOp = OP_OTHER;
                endcase
            end
            OPC_BR_LBC:   next_decodedOp = OP_BRANCH_LOW_BIT_CLEAR;       // RL15
            OPC_BR_LBS:   next_decodedOp = OP_BRANCH_LOW_BIT_SET;         // RL15
            OPC_HW_LOAD:  next_decodedOp = OP_PRIV_HW_LOAD;               // RL19
            OPC_HW_STORE: next_decodedOp = OP_PRIV_HW_STORE;              // RL20
            OPC_EXC_RET:  next_decodedOp = OP_PRIV_RETURN_FROM_EXCEPTION; // RL21
            OPC_IREG_RD:  next_decodedOp = OP_PRIV_INTERNAL_REG_READ;     // RL22
            OPC_IREG_WR:  next_decodedOp = OP_PRIV_INTERNAL_REG_WRITE;    // RL22
            default:      next_decodedOp = OP_OTHER;
        endcase
        // reserved opcodes override any decode
        if (isReserved(fieldBus.opcode, byteWordEnable)) begin
            next_illegal = 1'b1; // RL23
        end
        if (next_illegal) begin
            next_decodedOp = OP_NOP; // RL17
        end
    end

    // registered decode outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            decodedOp    <= OP_NOP; // RL24
            decodedFmt   <= FMT_MEMORY;
            decodeValid  <= 1'b0;
            illegalInstr <= 1'b0;
            opcodeOut    <= 6'h00;
            functionCode <= 26'h0;
        end else if (instrValid) begin
            decodedOp    <= next_decodedOp; // RL24
            decodedFmt   <= next_decodedFmt;
            decodeValid  <= 1'b1;
            illegalInstr <= next_illegal; // RL23
            opcodeOut    <= fieldBus.opcode;
            functionCode <= next_fnCode;
        end else begin
            decodedOp    <= OP_NOP;
            decodeValid  <= 1'b0;
            illegalInstr <= 1'b0;
        end
    end

    // exception-return redirect strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            redirectToExcPc <= 1'b0;
        end else begin
            redirectToExcPc <= instrValid && fieldBus.opcode == OPC_EXC_RET; // RL21
        end
    end
endmodule

// *** dv/isadec_fetch_model.sv ***
// fetch-side model that presents words to the decoder
`timescale 1ns/100ps
module isadec_fetch_model (
    input  wire logic        core_clk,   // core clock
    input  wire logic        sys_rst,    // synchronous reset
    input  wire logic        reqValid,   // bench asks for a word
    input  wire logic [31:0] reqWord,    // word to present
    output logic             instrValid, // word present
    output logic [31:0]      instrWord   // presented word
);
    logic [31:0] lastWord; // last word shown
    // remember the last presented word
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lastWord <= 32'h0;
        end else if (reqValid) begin
            lastWord <= reqWord;
        end
    end
    // idle bus shows the inverse so stale data never looks valid
    always_comb begin
        instrValid = reqValid;
        instrWord  = reqValid ? reqWord : ~lastWord;
    end
endmodule

// *** dv/isadec_opcode_decoder_asserts.sv ***
// port assertions for the opcode decoder
`timescale 1ns/100ps
module isadec_opcode_decoder_asserts
    import isadec_pkg::*;
(
    input wire logic        core_clk,        // core clock
    input wire logic        sys_rst,         // synchronous reset
    input wire logic        instrValid,      // word present
    input wire logic [31:0] instrWord,       // fetched word
    input wire logic        byteWordEnable,  // byte/word ops on
    input wire isadec_op_e  decodedOp,       // decoded operation
    input wire isadec_fmt_e decodedFmt,      // format
    input wire logic        decodeValid,     // decode present
    input wire logic        illegalInstr,    // illegal flag
    input wire logic [5:0]  opcodeOut,       // major opcode
    input wire logic [25:0] functionCode,    // function field
    input wire logic        redirectToExcPc  // exception return
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // a word taken with the given major opcode
    sequence sTake(logic [5:0] o);
        instrValid && instrWord[31:26] == o;
    endsequence
    AST_RESET_NOP: assert property (
        disable iff (1'b0) sys_rst |=>
            decodedOp == OP_NOP && !decodeValid && !illegalInstr && !redirectToExcPc)
        else $error("reset did not give a no-op decode");
    AST_ONE_CYCLE: assert property (
        instrValid |=> decodeValid ##1 (decodeValid == $past(instrValid)))
        else $error("decode valid latency wrong");
    AST_OPCODE: assert property (instrValid |=> opcodeOut == $past(instrWord[31:26]))
        else $error("major opcode not carried");
    AST_RESERVED: assert property (
        instrValid && instrWord[31:26] inside {[6'h01:6'h07]} |=>
            illegalInstr && decodedOp == OP_NOP)
        else $error("reserved opcode decoded");
    AST_BYTE_WORD: assert property (
        instrValid && instrWord[31:26] inside {6'h0A, 6'h0C, 6'h0D, 6'h0E} |=>
            illegalInstr == !$past(byteWordEnable))
        else $error("byte/word reservation wrong");
    AST_FP_FIELD: assert property (
        sTake(OPC_FP_IEEE) |=>
            decodedFmt == FMT_FLOAT && functionCode == {15'h0, $past(instrWord[15:5])})
        else $error("floating function field wrong");
    AST_OP_FIELD: assert property (
        sTake(OPC_INT_ARITH) |=>
            decodedFmt == FMT_OPER && functionCode == {19'h0, $past(instrWord[11:5])})
        else $error("operate function field wrong");
    AST_PRIV_FIELD: assert property (
        sTake(OPC_PRIV_CALL) |=>
            decodedFmt == FMT_PRIV && functionCode == $past(instrWord[25:0]))
        else $error("privileged call field wrong");
    AST_CORO: assert property (
        sTake(OPC_JUMP) ##0 instrWord[15:14] == 2'h3 |=> decodedOp == OP_COROUTINE_JUMP)
        else $error("coroutine jump not decoded");
    AST_REDIRECT: assert property (
        decodeValid || redirectToExcPc |->
            redirectToExcPc == ($past(instrValid) && $past(instrWord[31:26]) == OPC_EXC_RET))
        else $error("exception return strobe wrong");
endmodule
bind isadec_opcode_decoder isadec_opcode_decoder_asserts i_isadec_opcode_decoder_asserts (
    .core_clk(core_clk), .sys_rst(sys_rst), .instrValid(instrValid), .instrWord(instrWord),
    .byteWordEnable(byteWordEnable), .decodedOp(decodedOp), .decodedFmt(decodedFmt),
    .decodeValid(decodeValid), .illegalInstr(illegalInstr), .opcodeOut(opcodeOut),
    .functionCode(functionCode), .redirectToExcPc(redirectToExcPc));

// *** dv/test_isa_opcode_decoder.sv ***
// self-checking bench for the opcode decoder
`timescale 1ns/100ps
module test_isa_opcode_decoder;
    import isadec_pkg::*;
    logic        core_clk, sys_rst, reqValid, byteWordEnable, instrValid;
    logic [31:0] reqWord, instrWord;
    isadec_op_e  decodedOp;
    isadec_fmt_e decodedFmt;
    logic        decodeValid, illegalInstr, redirectToExcPc;
    logic [5:0]  opcodeOut;
    logic [25:0] functionCode;
    int          miscompares, numChecks;
    isadec_fetch_model i_isadec_fetch_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .reqValid(reqValid), .reqWord(reqWord), .instrValid(instrValid), .instrWord(instrWord));
    isadec_opcode_decoder i_isadec_opcode_decoder (.core_clk(core_clk), .sys_rst(sys_rst),
        .instrValid(instrValid), .instrWord(instrWord), .byteWordEnable(byteWordEnable),
        .decodedOp(decodedOp), .decodedFmt(decodedFmt), .decodeValid(decodeValid),
        .illegalInstr(illegalInstr), .opcodeOut(opcodeOut), .functionCode(functionCode),
        .redirectToExcPc(redirectToExcPc));
    // core clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // compare one value and count
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // present one word, let its decode land
    task automatic send(logic [31:0] w, logic bw);
        @(posedge core_clk);
        reqValid       <= 1'b1;
        reqWord        <= w;
        byteWordEnable <= bw;
        @(posedge core_clk);
        reqValid <= 1'b0;
        #1;
    endtask
    // decode one word; mask bit 0 checks format, bit 1 the function field
    task automatic dec(logic [5:0] opc, logic [25:0] body, logic bw, isadec_op_e op,
                       isadec_fmt_e fmt, logic ill, logic [1:0] mask, logic [25:0] fn);
        send({opc, body}, bw);
        check("valid", decodeValid, 1'b1);
        check("op", decodedOp, op);
        check("illegal", illegalInstr, ill);
        check("opcode", opcodeOut, opc);
        check("redirect", redirectToExcPc, opc == OPC_EXC_RET);
        if (mask[0]) check("fmt", decodedFmt, fmt);
        if (mask[1]) check("fn", functionCode, fn);
    endtask
    // reset values, then reset in mid-run
    task automatic t_reset();
        check("rst op", decodedOp, OP_NOP);
        check("rst fmt", decodedFmt, FMT_MEMORY);
        check("rst valid", decodeValid, 1'b0);
        check("rst illegal", illegalInstr, 1'b0);
        check("rst opcode", opcodeOut, 6'h00);
        check("rst fn", functionCode, 26'h0);
        check("rst redirect", redirectToExcPc, 1'b0);
        @(posedge core_clk);
        reqValid <= 1'b1;
        reqWord  <= {OPC_INT_ARITH, 26'h5A0};
        sys_rst  <= 1'b1;
        @(posedge core_clk);
        reqValid <= 1'b0;
        sys_rst  <= 1'b0;
        #1 check("mid op", decodedOp, OP_NOP);
        check("mid valid", decodeValid, 1'b0);
        check("mid illegal", illegalInstr, 1'b0);
        check("mid opcode", opcodeOut, 6'h00);
    endtask
    // integer compare, logical and multiply codes
    task automatic t_int();
        dec(OPC_INT_ARITH, 26'h2D << 5, 1'b0, OP_INT_CMP_EQUAL, FMT_OPER,
            1'b0, 2'b11, 26'h2D);
        dec(OPC_INT_ARITH, 26'h4D << 5, 1'b0, OP_INT_CMP_LESS, FMT_OPER,
            1'b0, 2'b11, 26'h4D);
        dec(OPC_INT_ARITH, 26'h6D << 5, 1'b0, OP_INT_CMP_LESS_EQUAL, FMT_OPER,
            1'b0, 2'b11, 26'h6D);
        dec(OPC_INT_LOGIC, 26'h00, 1'b0, OP_LOGIC_AND, FMT_OPER,
            1'b0, 2'b11, 26'h00);
        dec(OPC_INT_LOGIC, 26'h28 << 5, 1'b0, OP_LOGIC_OR_COMPLEMENT, FMT_OPER,
            1'b0, 2'b11, 26'h28);
        dec(OPC_INT_MUL, 26'h00, 1'b0, OP_MUL_LONGWORD, FMT_OPER,
            1'b0, 2'b11, 26'h00);
        dec(OPC_INT_MUL, 26'h11 << 5, 1'b0, OP_NOP, FMT_OPER,
            1'b1, 2'b00, 26'h0);
        dec(OPC_INT_MUL, 26'h20 << 5, 1'b0, OP_OTHER, FMT_OPER,
            1'b0, 2'b11, 26'h20);
        dec(6'h1C, 26'h31 << 5, 1'b0, OP_OTHER, FMT_OPER,
            1'b0, 2'b11, 26'h31);
    endtask
    // floating compare, convert and control codes
    task automatic t_fp();
        dec(OPC_FP_IEEE, 26'h0A7 << 5, 1'b0, OP_IEEE_DBL_CMP_LESS_EQUAL, FMT_FLOAT,
            1'b0, 2'b11, 26'h0A7);
        dec(OPC_FP_IEEE, 26'h0A4 << 5, 1'b0, OP_IEEE_DBL_CMP_UNORDERED, FMT_FLOAT,
            1'b0, 2'b11, 26'h0A4);
        dec(OPC_FP_LEGACY, 26'h0A5 << 5, 1'b0, OP_LEGACY_DBL_CMP_EQUAL, FMT_FLOAT,
            1'b0, 2'b11, 26'h0A5);
        dec(OPC_FP_LEGACY, 26'h0A7 << 5, 1'b0, OP_LEGACY_DBL_CMP_LESS_EQUAL, FMT_FLOAT,
            1'b0, 2'b11, 26'h0A7);
        dec(OPC_FP_IEEE, 26'h2AC << 5, 1'b0, OP_CVT_SINGLE_TO_DOUBLE, FMT_FLOAT,
            1'b0, 2'b11, 26'h2AC);
        dec(OPC_FP_MISC, 26'h025 << 5, 1'b0, OP_FP_CTRL_READ, FMT_FLOAT,
            1'b0, 2'b11, 26'h025);
        dec(OPC_FP_MISC, 26'h024 << 5, 1'b0, OP_FP_CTRL_WRITE, FMT_FLOAT,
            1'b0, 2'b11, 26'h024);
    endtask
    // displacement codes, jump hints and branches
    task automatic t_mem();
        isadec_op_e hop[4] = '{OP_JUMP, OP_JUMP_SUBROUTINE, OP_JUMP_RETURN, OP_COROUTINE_JUMP};
        dec(OPC_MISC, 26'h00C0, 1'b0, OP_CYCLE_COUNTER_READ, FMT_MEMFN,
            1'b0, 2'b11, 26'hC0);
        dec(OPC_MISC, 26'h1234, 1'b0, OP_NOP, FMT_MEMFN, 1'b1, 2'b00, 26'h0);
        dec(OPC_MISC, 26'h4000, 1'b0, OP_OTHER, FMT_MEMFN,
            1'b0, 2'b11, 26'h4000);
        for (int h = 0; h < 4; h++) begin
            dec(OPC_JUMP, {10'h0, h[1:0], 14'h1555}, 1'b0, hop[h], FMT_MEMBR,
                1'b0, 2'b01, 26'h0);
        end
        dec(OPC_BR_LBC, 26'h3FFFFFF, 1'b0, OP_BRANCH_LOW_BIT_CLEAR, FMT_BRANCH,
            1'b0, 2'b11, 26'h0);
        dec(OPC_BR_LBS, 26'h0000123, 1'b0, OP_BRANCH_LOW_BIT_SET, FMT_BRANCH,
            1'b0, 2'b11, 26'h0);
    endtask
    // privileged call and hardware opcodes
    task automatic t_priv();
        dec(OPC_PRIV_CALL, 26'h2000086, 1'b0, OP_PRIV_CALL, FMT_PRIV,
            1'b0, 2'b11, 26'h2000086);
        dec(OPC_HW_LOAD, 26'h0, 1'b0, OP_PRIV_HW_LOAD, FMT_MEMORY,
            1'b0, 2'b01, 26'h0);
        dec(OPC_HW_STORE, 26'h0, 1'b0, OP_PRIV_HW_STORE, FMT_MEMORY,
            1'b0, 2'b01, 26'h0);
        dec(OPC_EXC_RET, 26'h0, 1'b0, OP_PRIV_RETURN_FROM_EXCEPTION, FMT_MEMORY,
            1'b0, 2'b01, 26'h0);
        dec(OPC_IREG_RD, 26'h0, 1'b0, OP_PRIV_INTERNAL_REG_READ, FMT_MEMORY,
            1'b0, 2'b01, 26'h0);
        dec(OPC_IREG_WR, 26'h0, 1'b0, OP_PRIV_INTERNAL_REG_WRITE, FMT_MEMORY,
            1'b0, 2'b01, 26'h0);
    endtask
    // reserved opcodes, byte/word ones with the enable both ways
    task automatic t_reserved();
        logic [5:0] bw[4] = '{OPC_BYTE_LD, OPC_WORD_LD, OPC_WORD_ST, OPC_BYTE_ST};
        for (int o = 1; o <= 7; o++) begin
            dec(o[5:0], 26'h0, 1'b1, OP_NOP, FMT_MEMORY, 1'b1, 2'b00, 26'h0);
        end
        for (int i = 0; i < 8; i++) begin
            dec(bw[i % 4], 26'h0, i[2], i[2] ? OP_OTHER : OP_NOP, FMT_MEMORY,
                !i[2], 2'b00, 26'h0);
        end
    endtask
    // two words back to back, then idle
    task automatic t_back_to_back();
        @(posedge core_clk);
        reqValid <= 1'b1;
        reqWord  <= {OPC_INT_LOGIC, 26'h40 << 5};
        @(posedge core_clk);
        reqWord <= {OPC_INT_MUL, 26'h30 << 5};
        #1 check("b2b first", decodedOp, OP_LOGIC_XOR);
        @(posedge core_clk);
        reqValid <= 1'b0;
        #1 check("b2b second", decodedOp, OP_MUL_UNSIGNED_HIGH);
        check("b2b valid", decodeValid, 1'b1);
        @(posedge core_clk);
        #1 check("idle op", decodedOp, OP_NOP);
        check("idle valid", decodeValid, 1'b0);
        check("held fn", functionCode, 26'h30);
    endtask
    // counts, then verdict
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        sys_rst        = 1'b1;
        reqValid       = 1'b0;
        reqWord        = 32'h0;
        byteWordEnable = 1'b0;
        miscompares    = 0;
        numChecks      = 0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        t_reset();
        t_int();
        t_fp();
        t_mem();
        t_priv();
        t_reserved();
        t_back_to_back();
        print_verdict();
    end
endmodule
